//--- fsd_pkg.sv
// package for the final-storage stream decoder: pair kinds, field positions, reset values
// assumes a single clock domain and 8-bit byte transport
package fsd_pkg;
  localparam int BYTE_W = 8;
  localparam int MAG_W = 13;
  localparam int ID_W = 10;
  localparam int TYPE_W = 3;
  localparam int DIG_W = 2;
  // bit positions of A..H in the first byte
  localparam int BIT_A = 7;
  localparam int BIT_B = 6;
  localparam int BIT_C = 5;
  localparam int BIT_D = 4;
  localparam int BIT_E = 3;
  localparam int BIT_F = 2;
  localparam int BIT_G = 1;
  localparam int BIT_H = 0;
  localparam logic [2:0] DEF_ONES = 3'h7;
  localparam logic [5:0] START_CODE = 6'h3F; // top six bits of an FC start byte
  localparam logic [7:0] DUMMY_BYTE = 8'h7F;
  localparam int SIG_BYTES = 2;
  // register addresses (word aligned)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_VALUE = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hC;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  localparam logic [1:0] CNT_RESET = 2'h0;
  // pair classification
  typedef enum logic [TYPE_W-1:0] {
    PAIR_LOW = 3'h0,
    PAIR_START = 3'h1,
    PAIR_HI_FIRST = 3'h2,
    PAIR_HI_THIRD = 3'h3,
    PAIR_DUMMY = 3'h4,
    PAIR_UNKNOWN = 3'h5,
    PAIR_SIG = 3'h6
  } pair_kind_t;
endpackage

//--- pair_if.sv
// carrier between the pair classifier and the top: one completed pair per pulse
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface pair_if;
  import fsd_pkg::*;
  logic valid;
  logic [BYTE_W-1:0] first;
  logic [BYTE_W-1:0] second;
  logic is_sig;
  pair_kind_t kind;
  logic negative;
  logic [DIG_W-1:0] decimals;
  logic [MAG_W-1:0] magnitude;
  logic [ID_W-1:0] array_id;
  modport src (output valid, first, second, is_sig, kind, negative, decimals, magnitude, array_id);
  modport dst (input valid, first, second, is_sig, kind, negative, decimals, magnitude, array_id);
endinterface

//--- pair_classifier.sv
// pair classifier: decodes the registered byte pair into kind and fields
// assumes the first and second byte of a pair are held steady while valid is high
`timescale 1ns/1ps
module pair_classifier
  import fsd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic pair_valid_in,
  input wire logic [BYTE_W-1:0] first_in,
  input wire logic [BYTE_W-1:0] second_in,
  input wire logic sig_in,
  pair_if.src out
);
  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] first;
    logic [BYTE_W-1:0] second;
    logic is_sig;
    pair_kind_t kind;
    logic negative;
    logic [DIG_W-1:0] decimals;
    logic [MAG_W-1:0] magnitude;
    logic [ID_W-1:0] array_id;
  } cls_state_t;

  cls_state_t st_reg;
  cls_state_t st_next;

  // classify a first byte by its A..H pattern
  function automatic pair_kind_t classify(input logic [BYTE_W-1:0] b);
    pair_kind_t k;
    k = PAIR_UNKNOWN;
    if (b[BIT_D:BIT_F] != DEF_ONES) begin
      k = PAIR_LOW;
    end else if (b[BIT_A:BIT_F] == START_CODE) begin
      k = PAIR_START;
    end else if (!b[BIT_C]) begin
      k = PAIR_HI_FIRST;
    end else if (!b[BIT_A] && !b[BIT_B]) begin
      k = PAIR_HI_THIRD;
    end else if (b == DUMMY_BYTE) begin
      k = PAIR_DUMMY;
    end else begin
      k = PAIR_UNKNOWN;
    end
    return k;
  endfunction

  // build the decoded pair; signature pairs bypass value decoding
  always_comb begin
    st_next = st_reg;
    st_next.valid = pair_valid_in;
    if (pair_valid_in) begin
      st_next.first = first_in;
      st_next.second = second_in;
      st_next.is_sig = sig_in;
      st_next.kind = sig_in ? PAIR_SIG : classify(first_in);
      st_next.negative = 1'b0;
      st_next.decimals = 2'h0;
      st_next.magnitude = 13'h0000;
      st_next.array_id = 10'h000;
      if (!sig_in && st_next.kind == PAIR_LOW) begin
        st_next.negative = first_in[BIT_A];
        st_next.decimals = first_in[BIT_B:BIT_C];
        st_next.magnitude = {first_in[BIT_D:BIT_H], second_in};
      end
      if (!sig_in && st_next.kind == PAIR_START) begin
        st_next.array_id = {first_in[BIT_G:BIT_H], second_in};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out.valid = st_reg.valid;
  assign out.first = st_reg.first;
  assign out.second = st_reg.second;
  assign out.is_sig = st_reg.is_sig;
  assign out.kind = st_reg.kind;
  assign out.negative = st_reg.negative;
  assign out.decimals = st_reg.decimals;
  assign out.magnitude = st_reg.magnitude;
  assign out.array_id = st_reg.array_id;
endmodule

//--- final_storage_decoder.sv
// top of the final-storage dump decoder: byte intake, pair output and Avalon-MM registers
// assumes byte strobes synchronous to CLK_IN; END_IN marks the last data byte of a dump
`timescale 1ns/1ps

// Notes on behaviour
// - values are two-byte low or four-byte high
// - arrays open with FC start pair
// - two signature bytes follow dump, not data
// - first byte bits named A to H
// - low value sign is bit A
// - magnitude is D..H then second byte
// - bits B,C place the decimal point
// - D,E,F ones: type from other bits
// - start pair gives ten-bit array id
// - C zero: first half of four-byte value
// - A,B zero, C one: second half
module final_storage_decoder
  import fsd_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic BYTE_VALID_IN,
  input wire logic [7:0] BYTE_IN,
  input wire logic END_IN,
  output logic PAIR_VALID_OUT,
  output logic [2:0] PAIR_KIND_OUT,
  output logic [7:0] PAIR_FIRST_OUT,
  output logic [7:0] PAIR_SECOND_OUT,
  output logic PAIR_NEG_OUT,
  output logic [1:0] PAIR_DEC_OUT,
  output logic [12:0] PAIR_MAG_OUT,
  output logic [9:0] PAIR_ID_OUT,
  output logic DUMP_DONE_OUT,
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT
);
  typedef enum logic [2:0] {
    ST_DATA = 3'h1,
    ST_SIG = 3'h2,
    ST_DONE = 3'h4
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic have_first;
    logic [7:0] first;
    logic pv;
    logic [7:0] pf;
    logic [7:0] ps;
    logic psig;
    logic [1:0] sig_cnt;
    logic enable;
    logic err_sticky;
    logic in_array;
    logic hi_pending;
    logic [15:0] pair_count;
    logic [15:0] unknown_count;
    logic [15:0] signature;
    logic out_valid;
    logic [2:0] out_kind;
    logic [7:0] out_first;
    logic [7:0] out_second;
    logic out_neg;
    logic [1:0] out_dec;
    logic [12:0] out_mag;
    logic [9:0] out_id;
    logic done;
    logic ack;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;
  logic err_set; // an error is raised in this cycle
  pair_if pbus ();

  // decoding of each completed pair
  pair_classifier u_cls (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .pair_valid_in(s_reg.pv),
    .first_in(s_reg.pf),
    .second_in(s_reg.ps),
    .sig_in(s_reg.psig),
    .out(pbus.src)
  );

  // byte-enable merge of a 16-bit field write
  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // next-state: byte pairing, pair bookkeeping, register bus
  always_comb begin
    s_next = s_reg;
    s_next.pv = 1'b0;
    s_next.out_valid = 1'b0;
    s_next.done = 1'b0;
    s_next.ack = 1'b0;
    err_set = 1'b0;
    // gather bytes two at a time; after END_IN the next pair is the signature
    if (BYTE_VALID_IN && s_reg.enable && s_reg.phase != ST_DONE) begin
      if (!s_reg.have_first) begin
        s_next.have_first = 1'b1;
        s_next.first = BYTE_IN;
      end else begin
        s_next.have_first = 1'b0;
        s_next.pv = 1'b1;
        s_next.pf = s_reg.first;
        s_next.ps = BYTE_IN;
        s_next.psig = (s_reg.phase == ST_SIG);
        if (s_reg.phase == ST_SIG) begin
          s_next.phase = ST_DONE;
          s_next.signature = {s_reg.first, BYTE_IN};
        end else if (END_IN) begin
          s_next.phase = ST_SIG;
        end
      end
    end
    // account for each decoded pair and forward it
    if (pbus.valid) begin
      s_next.out_valid = 1'b1;
      s_next.out_kind = pbus.kind;
      s_next.out_first = pbus.first;
      s_next.out_second = pbus.second;
      s_next.out_neg = pbus.negative;
      s_next.out_dec = pbus.decimals;
      s_next.out_mag = pbus.magnitude;
      s_next.out_id = pbus.array_id;
      s_next.pair_count = s_reg.pair_count + 16'h0001;
      s_next.done = pbus.is_sig;
      if (pbus.kind == PAIR_START) begin
        s_next.in_array = 1'b1;
      end
      // the second half must follow the first half of a four-byte value
      if (pbus.kind == PAIR_HI_FIRST) begin
        s_next.hi_pending = 1'b1;
      end else if (pbus.kind == PAIR_HI_THIRD) begin
        s_next.hi_pending = 1'b0;
      end
      if (pbus.kind == PAIR_UNKNOWN) begin
        s_next.unknown_count = s_reg.unknown_count + 16'h0001;
      end
      // data before any start marker, or a broken four-byte value, sets the error flag
      if ((pbus.kind == PAIR_LOW || pbus.kind == PAIR_HI_FIRST) && !s_reg.in_array) begin
        s_next.err_sticky = 1'b1;
        err_set = 1'b1;
      end
      if ((pbus.kind == PAIR_HI_THIRD) != s_reg.hi_pending && pbus.kind != PAIR_SIG) begin
        s_next.err_sticky = 1'b1;
        err_set = 1'b1;
      end
    end
    // Avalon slave: one wait state, answer in the cycle after the request
    if ((AVS_READ_IN || AVS_WRITE_IN) && !s_reg.ack) begin
      s_next.ack = 1'b1;
      s_next.rdata = UNMAPPED_DATA;
      if (AVS_READ_IN) begin
        if (AVS_ADDRESS_IN == ADDR_CTRL) begin
          s_next.rdata = {31'h0, s_reg.enable};
        end else if (AVS_ADDRESS_IN == ADDR_STATUS) begin
          s_next.rdata = {s_reg.signature, 8'h00, 1'b0, s_reg.phase, s_reg.hi_pending, s_reg.in_array,
                          s_reg.have_first, s_reg.err_sticky};
        end else if (AVS_ADDRESS_IN == ADDR_VALUE) begin
          s_next.rdata = {s_reg.out_neg, s_reg.out_dec, 3'h0, s_reg.out_id, 3'h0, s_reg.out_mag};
        end else if (AVS_ADDRESS_IN == ADDR_COUNT) begin
          s_next.rdata = {s_reg.unknown_count, s_reg.pair_count};
        end
      end else begin
        if (AVS_ADDRESS_IN == ADDR_CTRL) begin
          if (AVS_BYTEENABLE_IN[0]) begin
            s_next.enable = AVS_WRITEDATA_IN[0];
            // bit 1 restarts the dump decoder
            if (AVS_WRITEDATA_IN[1]) begin
              s_next.phase = ST_DATA;
              s_next.have_first = 1'b0;
              s_next.in_array = 1'b0;
              s_next.hi_pending = 1'b0;
            end
          end
        end else if (AVS_ADDRESS_IN == ADDR_STATUS) begin
          // write one to clear error; a new error in the same cycle wins
          if (AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[0] && !err_set) begin
            s_next.err_sticky = 1'b0;
          end
        end else if (AVS_ADDRESS_IN == ADDR_COUNT) begin
          s_next.pair_count = be_merge(s_next.pair_count, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      s_reg <= '0;
      s_reg.phase <= ST_DATA;
      s_reg.enable <= 1'b1;
      s_reg.pair_count <= {14'h0000, CNT_RESET};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flip-flops
  assign PAIR_VALID_OUT = s_reg.out_valid;
  assign PAIR_KIND_OUT = s_reg.out_kind;
  assign PAIR_FIRST_OUT = s_reg.out_first;
  assign PAIR_SECOND_OUT = s_reg.out_second;
  assign PAIR_NEG_OUT = s_reg.out_neg;
  assign PAIR_DEC_OUT = s_reg.out_dec;
  assign PAIR_MAG_OUT = s_reg.out_mag;
  assign PAIR_ID_OUT = s_reg.out_id;
  assign DUMP_DONE_OUT = s_reg.done;
  assign AVS_READDATA_OUT = s_reg.rdata;
  assign AVS_WAITREQUEST_OUT = !s_reg.ack;
endmodule

//--- fsd_assertions.sv
// checker of pair decoding seen at the top ports
// assumes one clock and the active-low reset of the top
`timescale 1ns/1ps
module fsd_chk
  import fsd_pkg::*;
(
  input logic CLK_IN,
  input logic RSTN_IN,
  input logic PAIR_VALID_OUT,
  input logic [2:0] PAIR_KIND_OUT,
  input logic [7:0] PAIR_FIRST_OUT,
  input logic [7:0] PAIR_SECOND_OUT,
  input logic PAIR_NEG_OUT,
  input logic [1:0] PAIR_DEC_OUT,
  input logic [12:0] PAIR_MAG_OUT,
  input logic [9:0] PAIR_ID_OUT,
  input logic DUMP_DONE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // short names for the pair just shown
  wire [7:0] f = PAIR_FIRST_OUT;
  wire [2:0] k = PAIR_KIND_OUT;
  wire v = PAIR_VALID_OUT && k != 3'h6;
  property p_low;
    v && f[4:2] != 3'h7 |-> k == 3'h0 && PAIR_MAG_OUT == {f[4:0], PAIR_SECOND_OUT};
  endproperty
  a_low: assert property (p_low) else $error("low pair misdecoded");
  property p_sign;
    v && k == 3'h0 |-> PAIR_NEG_OUT == f[7] && PAIR_DEC_OUT == f[6:5];
  endproperty
  a_sign: assert property (p_sign) else $error("sign or decimals wrong");
  property p_start;
    v && f[7:2] == 6'h3F |-> k == 3'h1 && PAIR_ID_OUT == {f[1:0], PAIR_SECOND_OUT};
  endproperty
  a_start: assert property (p_start) else $error("array start wrong");
  property p_hi1;
    v && f[5:2] == 4'h7 |-> k == 3'h2 && PAIR_MAG_OUT == 13'h0;
  endproperty
  a_hi1: assert property (p_hi1) else $error("first half wrong");
  property p_hi3;
    v && f[7:2] == 6'h0F |-> k == 3'h3;
  endproperty
  a_hi3: assert property (p_hi3) else $error("second half wrong");
  property p_dummy;
    v && f == 8'h7F |-> k == 3'h4;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy wrong");
  property p_unk;
    v && (f[7:2] == 6'h2F || f[7:2] == 6'h1F && f != 8'h7F) |-> k == 3'h5 && PAIR_ID_OUT == 10'h0;
  endproperty
  a_unk: assert property (p_unk) else $error("unknown pair wrong");
  property p_done;
    PAIR_VALID_OUT |-> DUMP_DONE_OUT == (k == 3'h6);
  endproperty
  a_done: assert property (p_done) else $error("dump end wrong");
  property p_gap;
    PAIR_VALID_OUT |=> !PAIR_VALID_OUT && !DUMP_DONE_OUT;
  endproperty
  a_gap: assert property (p_gap) else $error("pairs too close");
endmodule
bind final_storage_decoder fsd_chk chk (.CLK_IN, .RSTN_IN, .PAIR_VALID_OUT, .PAIR_KIND_OUT, .PAIR_FIRST_OUT,
  .PAIR_SECOND_OUT, .PAIR_NEG_OUT, .PAIR_DEC_OUT, .PAIR_MAG_OUT, .PAIR_ID_OUT, .DUMP_DONE_OUT);

//--- fsd_logger.sv
// model of the logger sending a final-storage dump byte by byte
// assumes the decoder takes a byte at each rising edge with valid high
`timescale 1ns/1ps
module fsd_logger (
  input logic clk_in,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  output logic end_out
);
  initial begin
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
    end_out = 1'b0;
  end
  // one byte held up to its edge, then gap idle cycles
  task automatic put(input logic [7:0] b, input logic e, input int gap);
    byte_valid_out <= 1'b1;
    byte_out <= b;
    end_out <= e;
    @(posedge clk_in);
    repeat (gap) begin
      byte_valid_out <= 1'b0;
      end_out <= 1'b0;
      byte_out <= ~b; // released line shows no stale byte
      @(posedge clk_in);
    end
  endtask
  // a data pair; a dummy word always carries a zero second byte
  task automatic pair(input logic [7:0] f, s, input logic e, input int gap);
    put(f, 1'b0, gap);
    put((f == 8'h7F) ? 8'h00 : s, e, gap);
  endtask
  // two signature bytes after the last data pair, then idle
  task automatic sign(input logic [15:0] sg);
    put(sg[15:8], 1'b0, 0);
    put(sg[7:0], 1'b0, 3);
  endtask
endmodule

//--- test_logger_final_storage_decoder.sv
// self-checking bench for the final-storage dump decoder
// assumes the logger model and the bound checker beside the design
`timescale 1ns/1ps
module test_logger_final_storage_decoder;
  import fsd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic bv, ed, pv, ng, dn, rd, wr, wq;
  logic [7:0] bt, pf, ps;
  logic [2:0] pk;
  logic [1:0] dc;
  logic [12:0] mg;
  logic [9:0] id;
  logic [3:0] ad;
  logic [31:0] wd, rq, r;
  logic [15:0] sg;
  logic [28:0] e, q[$];
  integer seed = 32'hAC3E;
  int n_errors = 0, n_tests = 0, cyc = 0, n_unk = 0;
  always #2 clk = ~clk;
  final_storage_decoder dut (.CLK_IN(clk), .RSTN_IN(rstn), .BYTE_VALID_IN(bv), .BYTE_IN(bt), .END_IN(ed),
    .PAIR_VALID_OUT(pv), .PAIR_KIND_OUT(pk), .PAIR_FIRST_OUT(pf), .PAIR_SECOND_OUT(ps), .PAIR_NEG_OUT(ng),
    .PAIR_DEC_OUT(dc), .PAIR_MAG_OUT(mg), .PAIR_ID_OUT(id), .DUMP_DONE_OUT(dn), .AVS_ADDRESS_IN(ad),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rq), .AVS_WAITREQUEST_OUT(wq));
  fsd_logger lg (.clk_in(clk), .byte_valid_out(bv), .byte_out(bt), .end_out(ed));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one bus transfer held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd <= ~w;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    r = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // kind and fields a pair must decode to
  function automatic logic [28:0] want(input logic [7:0] f, s, input logic sig);
    logic [2:0] k;
    k = (f[4:2] != 3'h7) ? 3'h0 : (f[7:5] == 3'h7) ? 3'h1 : !f[5] ? 3'h2 :
      (f[7:6] == 2'h0) ? 3'h3 : (f == 8'h7F) ? 3'h4 : 3'h5;
    if (sig)
      k = 3'h6;
    return {k, (k == 3'h0) ? {f, s} : 16'h0, (k == 3'h1) ? {f[1:0], s} : 10'h0};
  endfunction
  task automatic tx(input logic [7:0] f, s, input logic last);
    q.push_back(want(f, s, 1'b0));
    lg.pair(f, s, last, $unsigned($random(seed)) % 3);
  endtask
  // one dump: start pair, random pairs, last pair, signature
  task automatic dump(input int n);
    logic [7:0] f, s;
    int c;
    tx({6'h3F, 2'($random(seed))}, 8'($random(seed)), 1'b0);
    repeat (n) begin
      c = $unsigned($random(seed)) % 4;
      f = 8'($random(seed));
      {f[4:0], s} = 13'($unsigned($random(seed)) % 7000);
      if (c < 2)
        tx(f, s, 1'b0);
      else if (c == 2) begin
        tx({f[7:6], 4'h7, f[1:0]}, s, 1'b0);
        tx({2'h0, 4'hF, f[1:0]}, s, 1'b0);
      end else begin
        f = {f[7] ? 3'h5 : 3'h3, 3'h7, f[1:0]};
        n_unk += (f != 8'h7F);
        tx(f, s, 1'b0);
      end
    end
    tx(8'h1A, 8'h2B, 1'b1);
    q.push_back(want(8'h0, 8'h0, 1'b1));
    lg.sign(sg);
    repeat (8) @(posedge clk);
    chk("left", q.size(), 0);
  endtask
  // every decoded pair against the oldest expectation; run ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      conclude();
    end
    if (pv === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : '1;
      chk("kind", pk, e[28:26]);
      chk("fields", {ng, dc, mg, id}, e[25:0]);
      chk("done", dn, e[28:26] == 3'h6);
    end
  end
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    ad = 4'h0;
    wd = 32'h0;
    sg = 16'($random(seed));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", r, 32'h1);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", r, UNMAPPED_DATA);
    dump(40);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status", {r[31:16], r[6:4], r[0]}, {sg, 3'h4, 1'b0});
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk("unknowns", r[31:16], n_unk);
    $display("random dump done");
    bus(1'b1, ADDR_CTRL, 32'h2);
    lg.pair(8'h12, 8'h34, 1'b0, 1);
    bus(1'b1, ADDR_CTRL, 32'h1);
    tx(8'hFF, 8'hFF, 1'b0);
    tx(8'hFB, 8'h57, 1'b0);
    tx(8'h7F, 8'hA5, 1'b0);
    dump(10);
    $display("corner dump done");
    // data before a start pair sets the error flag; write one clears it
    bus(1'b1, ADDR_CTRL, 32'h3);
    q.push_back(want(8'h12, 8'h34, 1'b0));
    lg.pair(8'h12, 8'h34, 1'b0, 1);
    repeat (4) @(posedge clk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("err set", r[0], 1'b1);
    bus(1'b1, ADDR_STATUS, 32'h1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("err clear", r[0], 1'b0);
    bus(1'b1, ADDR_COUNT, 32'h5);
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk("count", r[15:0], 16'h0005);
    $display("error flag test done");
    conclude();
  end
endmodule
